// ===== pkg/icsr_pkg.sv
// Purpose: Shared constants for the interrupt control and status register set
// Assumes: 16-bit register port, word-indexed addresses
// Notes: Source count spans five flag words and fills seventeen priority words
package icsr_pkg;
  localparam int ICSR_NUM_SRC = 68;
  localparam int ICSR_DATA_W = 16;
  localparam int ICSR_ADDR_W = 6;
  localparam int ICSR_NUM_FLAG_WORDS = 5;
  localparam int ICSR_NUM_PRIO_WORDS = 17;
  localparam int ICSR_SRC_PER_PRIO_WORD = 4;

  // Register offsets
  localparam logic [5:0] ICSR_CTRL_ONE_OFS = 6'h00;
  localparam logic [5:0] ICSR_CTRL_TWO_OFS = 6'h01;
  localparam logic [5:0] ICSR_FLAG_BASE_OFS = 6'h02;
  localparam logic [5:0] ICSR_ENABLE_BASE_OFS = 6'h07;
  localparam logic [5:0] ICSR_PRIO_BASE_OFS = 6'h0c;
  localparam logic [5:0] ICSR_PENDING_OFS = 6'h1d;
  localparam logic [5:0] ICSR_CPU_STATUS_OFS = 6'h1e;
  localparam logic [5:0] ICSR_CORE_CONTROL_OFS = 6'h1f;

  // Control register one fields
  localparam int ICSR_NEST_DIS_BIT = 15;
  localparam int ICSR_ACC_A_OVF_BIT = 14;
  localparam int ICSR_ACC_B_OVF_BIT = 13;
  localparam int ICSR_ACC_A_CAT_BIT = 12;
  localparam int ICSR_ACC_B_CAT_BIT = 11;
  localparam int ICSR_ACC_A_TE_BIT = 10;
  localparam int ICSR_ACC_B_TE_BIT = 9;
  localparam int ICSR_CAT_TE_BIT = 8;
  localparam int ICSR_BAD_SHIFT_BIT = 7;
  localparam int ICSR_DMA_ERR_BIT = 5;
  localparam int ICSR_MATH_ERR_BIT = 4;

  // Control register two fields
  localparam int ICSR_ALT_TABLE_BIT = 15;
  localparam int ICSR_EDGE_SEL_LSB = 0;

  // Status and core control fields
  localparam int ICSR_IPL_LSB = 5;
  localparam int ICSR_UPPER_BIT = 3;

  // Pending vector fields
  localparam int ICSR_VEC_LSB = 0;
  localparam int ICSR_LEVEL_LSB = 8;

  // Vector numbering and external pin mapping
  localparam logic [6:0] ICSR_FIRST_VECTOR = 7'h08;
  localparam int ICSR_EXT_ZERO_SRC = 0;
  localparam int ICSR_EXT_ONE_SRC = 20;
  localparam int ICSR_EXT_TWO_SRC = 29;

  // Reset values and highest low level
  localparam logic [2:0] ICSR_PRIO_RESET = 3'h4;
  localparam logic [2:0] ICSR_IPL_RESET = 3'h0;
  localparam logic [2:0] ICSR_LEVEL_MAX_LOW = 3'h7;
endpackage : icsr_pkg

// ===== src/icsr_edge_detect.sv
// Purpose: Edge detection for the three external interrupt inputs
// Assumes: Pins are synchronous to clk
// Notes: Polarity bit high selects falling edge
`timescale 1ns/10ps
module icsr_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Pins and polarity
  input wire logic [2:0] extPin,
  input wire logic [2:0] edgeSelect,
  // Events
  output logic [2:0] extEvent
);
  logic [2:0] pinPrev_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinPrev_reg <= 3'h0;
    end else begin
      pinPrev_reg <= extPin;
    end
  end

  // Falling edge when selected, otherwise rising edge
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      extEvent[i] = edgeSelect[i] ? (pinPrev_reg[i] & ~extPin[i])
                                  : (~pinPrev_reg[i] & extPin[i]);
    end
  end
endmodule : icsr_edge_detect

// ===== src/icsr_resolver.sv
// Purpose: Picks the most urgent eligible interrupt source
// Assumes: Flat priority vector, three bits per source
// Notes: Lowest source index wins a tie
`timescale 1ns/10ps
module icsr_resolver (
  // Source state
  input wire logic [icsr_pkg::ICSR_NUM_SRC-1:0] flags,
  input wire logic [icsr_pkg::ICSR_NUM_SRC-1:0] enables,
  input wire logic [icsr_pkg::ICSR_NUM_SRC*3-1:0] prios,
  // Current level
  input wire logic [3:0] cpuLevel,
  // Winner
  output logic winValid,
  output logic [6:0] winIndex,
  output logic [2:0] winPrio
);
  import icsr_pkg::*;

  // Scan from the top so lower indices overwrite equal priorities
  always_comb begin
    winValid = 1'b0;
    winIndex = 7'h00;
    winPrio = 3'h0;
    for (int i = ICSR_NUM_SRC - 1; i >= 0; i--) begin
      if (flags[i] && enables[i] && ({1'b0, prios[i*3 +: 3]} > cpuLevel) &&
          (!winValid || prios[i*3 +: 3] >= winPrio)) begin
        winValid = 1'b1;
        winIndex = 7'(i);
        winPrio = prios[i*3 +: 3];
      end
    end
  end
endmodule : icsr_resolver

// ===== src/icsr_regs.sv
// Purpose: Interrupt controller control and status registers
// Assumes: Single clock, word-indexed register port, read data one cycle later
// Notes: Core loads the priority level on acceptance and return
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
// Operation
// - Thirty-two controller registers are software visible
// - Hardware sets request flags, software clears them
// - Disabled sources never raise a processor interrupt
// - Each source has three-bit priority, eight levels
// - Pending register latches vector number and level
// - Latched level equals pending source priority
// - Sources map to bits in vector order
// - Status bits 7:5 hold writable low level
// - Upper level bit is read-only to software
// - Level is upper bit over three low bits
// - Upper bit or level seven blocks user interrupts
// - Upper bit set means level above seven
// - Nesting disable makes low level bits read-only
// - Control one bit 15 disables interrupt nesting
// - Bits 14:11 flag overflow and catastrophic overflow
// - Bits 10:8 enable accumulator overflow traps
// - Bit 7 flags invalid accumulator shift
// - Bits 5 and 4 flag DMA, math traps
// - Control two governs pins and vector table
// - Control two bit 15 selects alternate table
// - Control two bits 2:0 select pin edges
module icsr_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [icsr_pkg::ICSR_ADDR_W-1:0] regAddr,
  input wire logic [icsr_pkg::ICSR_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [icsr_pkg::ICSR_DATA_W-1:0] regRdData,
  // Interrupt sources
  input wire logic [icsr_pkg::ICSR_NUM_SRC-1:0] srcEvent,
  input wire logic [2:0] extPin,
  // Arithmetic and DMA trap events
  input wire logic accAOverflow,
  input wire logic accBOverflow,
  input wire logic accACatastrophic,
  input wire logic accBCatastrophic,
  input wire logic badShift,
  input wire logic dmaError,
  // Core side
  input wire logic coreInHandler,
  input wire logic irqAck,
  input wire logic coreLevelLoad,
  input wire logic [3:0] coreLevelValue,
  output logic irqRequest,
  output logic [6:0] pendingVectorNumber,
  output logic [3:0] pendingLevel,
  output logic [3:0] cpuPriorityLevel,
  output logic mathTrapRequest,
  output logic dmaTrapRequest,
  output logic alternateTableSelect
);
  import icsr_pkg::*;

  logic [ICSR_NUM_SRC-1:0] requestFlag_reg;
  logic [ICSR_NUM_SRC-1:0] sourceEnable_reg;
  logic [ICSR_NUM_SRC*3-1:0] sourcePrio_reg;
  logic [15:0] ctrlOne_reg;
  logic [15:0] ctrlTwo_reg;
  logic [2:0] iplLow_reg;
  logic cpuLevelUpperBit_reg;
  logic [6:0] pendVector_reg;
  logic [3:0] pendLevel_reg;
  logic [ICSR_DATA_W-1:0] rdData_reg;
  logic [ICSR_DATA_W-1:0] rdData_next;
  logic [2:0] extEvent;
  logic [ICSR_NUM_SRC-1:0] hwSet;
  logic winValid;
  logic [6:0] winIndex;
  logic [2:0] winPrio;
  logic nestingDisable;
  logic userBlocked;
  logic mathSet;
  logic accAOvfSet;
  logic accBOvfSet;
  logic accACatSet;
  logic accBCatSet;

  assign nestingDisable = ctrlOne_reg[ICSR_NEST_DIS_BIT];

  icsr_edge_detect uEdge (
    .clk(clk),
    .rst_b(rst_b),
    .extPin(extPin),
    .edgeSelect(ctrlTwo_reg[ICSR_EDGE_SEL_LSB +: 3]),
    .extEvent(extEvent)
  );

  // External pins feed their own vector-ordered flag positions
  always_comb begin
    hwSet = srcEvent;
    hwSet[ICSR_EXT_ZERO_SRC] = srcEvent[ICSR_EXT_ZERO_SRC] | extEvent[0];
    hwSet[ICSR_EXT_ONE_SRC] = srcEvent[ICSR_EXT_ONE_SRC] | extEvent[1];
    hwSet[ICSR_EXT_TWO_SRC] = srcEvent[ICSR_EXT_TWO_SRC] | extEvent[2];
  end

  // Request flags: a hardware set wins over a same-cycle software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      requestFlag_reg <= '0;
    end else begin
      for (int j = 0; j < ICSR_NUM_SRC; j++) begin
        if (hwSet[j]) begin
          requestFlag_reg[j] <= 1'b1;
        end else if (regWrite && regAddr == ICSR_FLAG_BASE_OFS + 6'(j / 16)) begin
          requestFlag_reg[j] <= regWrData[j % 16];
        end
      end
    end
  end

  // Source enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sourceEnable_reg <= '0;
    end else begin
      for (int j = 0; j < ICSR_NUM_SRC; j++) begin
        if (regWrite && regAddr == ICSR_ENABLE_BASE_OFS + 6'(j / 16)) begin
          sourceEnable_reg[j] <= regWrData[j % 16];
        end
      end
    end
  end

  // Source priorities, four per word in nibbles, bits 2:0 of each
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sourcePrio_reg <= {ICSR_NUM_SRC{ICSR_PRIO_RESET}};
    end else begin
      for (int j = 0; j < ICSR_NUM_SRC; j++) begin
        if (regWrite && regAddr == ICSR_PRIO_BASE_OFS + 6'(j / ICSR_SRC_PER_PRIO_WORD)) begin
          sourcePrio_reg[j*3 +: 3] <= regWrData[(j % ICSR_SRC_PER_PRIO_WORD) * 4 +: 3];
        end
      end
    end
  end

  // Accumulator overflow trap conditions gated by their enables, bad shift ungated
  assign accAOvfSet = accAOverflow & ctrlOne_reg[ICSR_ACC_A_TE_BIT];
  assign accBOvfSet = accBOverflow & ctrlOne_reg[ICSR_ACC_B_TE_BIT];
  assign accACatSet = accACatastrophic & ctrlOne_reg[ICSR_CAT_TE_BIT];
  assign accBCatSet = accBCatastrophic & ctrlOne_reg[ICSR_CAT_TE_BIT];
  assign mathSet = accAOvfSet | accBOvfSet | accACatSet | accBCatSet | badShift;

  // Control register one: trap flags set by hardware, set wins over write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlOne_reg <= 16'h0000;
    end else begin
      if (regWrite && regAddr == ICSR_CTRL_ONE_OFS) begin
        ctrlOne_reg <= regWrData & 16'hffb0;
      end
      if (accAOvfSet) begin
        ctrlOne_reg[ICSR_ACC_A_OVF_BIT] <= 1'b1;
      end
      if (accBOvfSet) begin
        ctrlOne_reg[ICSR_ACC_B_OVF_BIT] <= 1'b1;
      end
      if (accACatSet) begin
        ctrlOne_reg[ICSR_ACC_A_CAT_BIT] <= 1'b1;
      end
      if (accBCatSet) begin
        ctrlOne_reg[ICSR_ACC_B_CAT_BIT] <= 1'b1;
      end
      if (badShift) begin
        ctrlOne_reg[ICSR_BAD_SHIFT_BIT] <= 1'b1;
      end
      if (dmaError) begin
        ctrlOne_reg[ICSR_DMA_ERR_BIT] <= 1'b1;
      end
      if (mathSet) begin
        ctrlOne_reg[ICSR_MATH_ERR_BIT] <= 1'b1;
      end
    end
  end

  // Control register two: table select and edge polarities
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlTwo_reg <= 16'h0000;
    end else if (regWrite && regAddr == ICSR_CTRL_TWO_OFS) begin
      ctrlTwo_reg <= regWrData & 16'h8007;
    end
  end

  // Low level bits: core loads win, software writes only without nesting disable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      iplLow_reg <= ICSR_IPL_RESET;
    end else if (coreLevelLoad) begin
      iplLow_reg <= coreLevelValue[2:0];
    end else if (irqAck) begin
      iplLow_reg <= nestingDisable ? ICSR_LEVEL_MAX_LOW : pendLevel_reg[2:0];
    end else if (regWrite && regAddr == ICSR_CPU_STATUS_OFS && !nestingDisable) begin
      iplLow_reg <= regWrData[ICSR_IPL_LSB +: 3];
    end
  end

  // Upper level bit only moves under core control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuLevelUpperBit_reg <= 1'b0;
    end else if (coreLevelLoad) begin
      cpuLevelUpperBit_reg <= coreLevelValue[3];
    end
  end

  assign cpuPriorityLevel = {cpuLevelUpperBit_reg, iplLow_reg};

  icsr_resolver uResolve (
    .flags(requestFlag_reg),
    .enables(sourceEnable_reg),
    .prios(sourcePrio_reg),
    .cpuLevel(cpuPriorityLevel),
    .winValid(winValid),
    .winIndex(winIndex),
    .winPrio(winPrio)
  );

  // Pending vector and level latch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pendVector_reg <= 7'h00;
      pendLevel_reg <= 4'h0;
    end else if (winValid) begin
      pendVector_reg <= winIndex + ICSR_FIRST_VECTOR;
      pendLevel_reg <= {1'b0, winPrio};
    end
  end

  assign pendingVectorNumber = pendVector_reg;
  assign pendingLevel = pendLevel_reg;

  assign userBlocked = cpuLevelUpperBit_reg || (iplLow_reg == ICSR_LEVEL_MAX_LOW) ||
                       (nestingDisable && coreInHandler);
  assign irqRequest = winValid && !userBlocked;
  assign mathTrapRequest = ctrlOne_reg[ICSR_MATH_ERR_BIT];
  assign dmaTrapRequest = ctrlOne_reg[ICSR_DMA_ERR_BIT];
  assign alternateTableSelect = ctrlTwo_reg[ICSR_ALT_TABLE_BIT];

  // Read mux
  always_comb begin
    rdData_next = 16'h0000;
    if (regAddr == ICSR_CTRL_ONE_OFS) begin
      rdData_next = ctrlOne_reg;
    end else if (regAddr == ICSR_CTRL_TWO_OFS) begin
      rdData_next = ctrlTwo_reg;
    end else if (regAddr == ICSR_PENDING_OFS) begin
      rdData_next[ICSR_VEC_LSB +: 7] = pendVector_reg;
      rdData_next[ICSR_LEVEL_LSB +: 4] = pendLevel_reg;
    end else if (regAddr == ICSR_CPU_STATUS_OFS) begin
      rdData_next[ICSR_IPL_LSB +: 3] = iplLow_reg;
    end else if (regAddr == ICSR_CORE_CONTROL_OFS) begin
      rdData_next[ICSR_UPPER_BIT] = cpuLevelUpperBit_reg;
    end
    for (int j = 0; j < ICSR_NUM_SRC; j++) begin
      if (regAddr == ICSR_FLAG_BASE_OFS + 6'(j / 16)) begin
        rdData_next[j % 16] = requestFlag_reg[j];
      end
      if (regAddr == ICSR_ENABLE_BASE_OFS + 6'(j / 16)) begin
        rdData_next[j % 16] = sourceEnable_reg[j];
      end
      if (regAddr == ICSR_PRIO_BASE_OFS + 6'(j / ICSR_SRC_PER_PRIO_WORD)) begin
        rdData_next[(j % ICSR_SRC_PER_PRIO_WORD) * 4 +: 3] = sourcePrio_reg[j*3 +: 3];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_reg <= 16'h0000;
    end else begin
      rdData_reg <= regRead ? rdData_next : 16'h0000;
    end
  end

  assign regRdData = rdData_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_flag_zero_write;
    regWrite && regAddr == ICSR_FLAG_BASE_OFS;
  endsequence

  a_flag_set_sticks: assert property (srcEvent[5] |=> requestFlag_reg[5])
    else $error("Source event did not set its flag");
  a_flag_holds: assert property (requestFlag_reg[0] &&
    !(regWrite && regAddr == ICSR_FLAG_BASE_OFS) |=> requestFlag_reg[0])
    else $error("Flag cleared without a software write");
  a_flag_zero_write: assert property (s_flag_zero_write ##0 !hwSet[0]
    |=> requestFlag_reg[0] == $past(regWrData[0]))
    else $error("Software write to a flag did not land");
  a_edge_flag: assert property (extEvent[0] |=>
    requestFlag_reg[ICSR_EXT_ZERO_SRC])
    else $error("Pin edge did not set its flag");
  a_disabled_quiet: assert property (irqRequest |->
    sourceEnable_reg[winIndex] && requestFlag_reg[winIndex])
    else $error("Request raised for disabled or idle source");
  a_level_match: assert property (winValid |=> pendLevel_reg == {1'b0, $past(winPrio)})
    else $error("Latched level differs from source priority");
  a_vector_map: assert property (winValid |=>
    pendVector_reg == $past(winIndex) + ICSR_FIRST_VECTOR)
    else $error("Vector number not index plus eight");
  a_pend_hold: assert property (!winValid |=> $stable(pendVector_reg))
    else $error("Pending vector moved with no winner");
  a_upper_blocks: assert property (cpuLevelUpperBit_reg |-> !irqRequest)
    else $error("User interrupt raised above level seven");
  a_seven_blocks: assert property (iplLow_reg == 3'h7 |-> !irqRequest)
    else $error("User interrupt raised at level seven");
  a_nest_blocks: assert property (nestingDisable && coreInHandler |-> !irqRequest)
    else $error("Nested request raised under nesting disable");
  a_nest_ack_seven: assert property (irqAck && nestingDisable && !coreLevelLoad
    |=> iplLow_reg == ICSR_LEVEL_MAX_LOW)
    else $error("Acceptance under nesting disable did not go to seven");
  a_upper_readonly: assert property (regWrite && regAddr == ICSR_CORE_CONTROL_OFS &&
    !coreLevelLoad |=> $stable(cpuLevelUpperBit_reg))
    else $error("Software changed the upper level bit");
  a_level_load: assert property (coreLevelLoad |=>
    cpuPriorityLevel == $past(coreLevelValue))
    else $error("Core level load did not land");
  a_nest_readonly: assert property (nestingDisable && !coreLevelLoad && !irqAck
    ##0 regWrite && regAddr == ICSR_CPU_STATUS_OFS |=> $stable(iplLow_reg))
    else $error("Level bits written under nesting disable");
  a_ipl_write: assert property (regWrite && regAddr == ICSR_CPU_STATUS_OFS &&
    !nestingDisable && !coreLevelLoad && !irqAck
    |=> iplLow_reg == $past(regWrData[7:5]))
    else $error("Level bits did not take the write");
  a_trap_gated: assert property (accAOverflow && !ctrlOne_reg[ICSR_ACC_A_TE_BIT] &&
    !(regWrite && regAddr == ICSR_CTRL_ONE_OFS)
    |=> $stable(ctrlOne_reg[ICSR_ACC_A_OVF_BIT]))
    else $error("Disabled overflow trap changed its flag");
  a_math_flag: assert property (badShift |=>
    ctrlOne_reg[ICSR_BAD_SHIFT_BIT] && ctrlOne_reg[ICSR_MATH_ERR_BIT])
    else $error("Shift error did not set its flags");
  a_read_idle: assert property (!regRead |=> regRdData == 16'h0000)
    else $error("Read data present without a read strobe");
endmodule : icsr_regs

// ===== verif/icsr_core_model.sv
// Purpose: Core side partner that accepts pending interrupts
// Assumes: Acknowledge is a one-cycle pulse, handler state is a level
// Notes: ackDelay picks a prompt or slow acceptance
`timescale 1ns/10ps
module icsr_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control from bench
  input wire logic ackEnable,
  input wire logic [1:0] ackDelay,
  // Block side
  input wire logic irqRequest,
  output logic irqAck,
  output logic coreInHandler
);
  logic [1:0] waitCnt;

  // Accept once after the chosen wait, then stay in the handler
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqAck <= 1'b0;
      coreInHandler <= 1'b0;
      waitCnt <= 2'h0;
    end else begin
      irqAck <= 1'b0;
      if (!ackEnable) begin
        coreInHandler <= 1'b0;
        waitCnt <= 2'h0;
      end else if (irqAck) begin
        coreInHandler <= 1'b1;
      end else if (irqRequest && !coreInHandler) begin
        if (waitCnt == ackDelay) irqAck <= 1'b1;
        else waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule : icsr_core_model

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the interrupt register set
// Assumes: Reads return data one cycle after the strobe
// Notes: Read expectations queue up, a monitor compares them
`timescale 1ns/10ps
module testbench;
  import icsr_pkg::*;
  logic clk, rst_b, regWrite, regRead, rdPend, ackEnable, coreLevelLoad;
  logic [5:0] regAddr, trapEv;
  logic [15:0] regWrData, regRdData;
  logic [67:0] srcEvent;
  logic [2:0] extPin;
  logic [1:0] ackDelay;
  logic [3:0] coreLevelValue, pendingLevel, cpuPriorityLevel;
  logic [6:0] pendingVectorNumber;
  logic irqRequest, irqAck, coreInHandler, mathTrapRequest, dmaTrapRequest, alternateTableSelect;
  logic [15:0] expQ[$];
  logic [31:0] seed;
  int bad_count, cmp_count, cyc, k, p;
  int extSrc[3] = '{ICSR_EXT_ZERO_SRC, ICSR_EXT_ONE_SRC, ICSR_EXT_TWO_SRC};
  logic [15:0] trapExp[6] = '{16'h4710, 16'h2710, 16'h1710, 16'h0f10, 16'h0790, 16'h0720};

  icsr_regs dut_u (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .srcEvent(srcEvent),
    .extPin(extPin), .accAOverflow(trapEv[0]), .accBOverflow(trapEv[1]),
    .accACatastrophic(trapEv[2]), .accBCatastrophic(trapEv[3]), .badShift(trapEv[4]),
    .dmaError(trapEv[5]), .coreInHandler(coreInHandler), .irqAck(irqAck),
    .coreLevelLoad(coreLevelLoad), .coreLevelValue(coreLevelValue), .irqRequest(irqRequest),
    .pendingVectorNumber(pendingVectorNumber), .pendingLevel(pendingLevel),
    .cpuPriorityLevel(cpuPriorityLevel), .mathTrapRequest(mathTrapRequest),
    .dmaTrapRequest(dmaTrapRequest), .alternateTableSelect(alternateTableSelect));
  icsr_core_model core_u (.clk(clk), .rst_b(rst_b), .ackEnable(ackEnable),
    .ackDelay(ackDelay), .irqRequest(irqRequest), .irqAck(irqAck),
    .coreInHandler(coreInHandler));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd
  task automatic ev(input logic [67:0] m);
    @(posedge clk);
    srcEvent <= m;
    @(posedge clk);
    srcEvent <= '0;
  endtask : ev
  task automatic see();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : see
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    rdPend <= regRead;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // Read data stands only in the cycle after the strobe
  always @(negedge clk) begin
    if (rdPend === 1'b1 && expQ.size() > 0) chk(regRdData, expQ.pop_front());
  end

  initial begin
    {regWrite, regRead, rdPend, ackEnable, coreLevelLoad} = '0;
    {regAddr, trapEv, regWrData, srcEvent, extPin, ackDelay, coreLevelValue} = '0;
    seed = 32'd43;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(ICSR_PRIO_BASE_OFS, 16'h4444);
    rd(6'h1c, 16'h4444);
    rd(ICSR_PENDING_OFS, 16'h0000);
    wr(6'h25, 16'hffff);
    rd(6'h25, 16'h0000);
    wr(ICSR_CTRL_ONE_OFS, 16'hffff);
    rd(ICSR_CTRL_ONE_OFS, 16'hffb0);
    wr(ICSR_CTRL_ONE_OFS, 16'h0000);
    wr(ICSR_CTRL_TWO_OFS, 16'hffff);
    rd(ICSR_CTRL_TWO_OFS, 16'h8007);
    @(negedge clk);
    chk(alternateTableSelect, 1'b1);
    wr(ICSR_CTRL_TWO_OFS, 16'h0000);
    @(negedge clk);
    chk(alternateTableSelect, 1'b0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr(ICSR_CTRL_ONE_OFS, 16'h0700);
      @(posedge clk);
      trapEv <= 6'h1 << i;
      @(posedge clk);
      trapEv <= '0;
      rd(ICSR_CTRL_ONE_OFS, trapExp[i]);
      chk(mathTrapRequest, trapExp[i][4]);
      chk(dmaTrapRequest, trapExp[i][5]);
    end
    wr(ICSR_CTRL_ONE_OFS, 16'h0000);
    @(posedge clk);
    trapEv <= 6'h0f;
    @(posedge clk);
    trapEv <= '0;
    rd(ICSR_CTRL_ONE_OFS, 16'h0000);
    chk(mathTrapRequest, 1'b0);
    $display("test traps done");
    for (int n = 0; n < 3; n++) begin
      k = xs() % ICSR_NUM_SRC;
      p = 1 + xs() % 7;
      wr(ICSR_ENABLE_BASE_OFS + 6'(k / 16), 16'h1 << (k % 16));
      wr(ICSR_PRIO_BASE_OFS + 6'(k / 4), 16'(p) << (4 * (k % 4)));
      ev(68'h1 << k);
      rd(ICSR_FLAG_BASE_OFS + 6'(k / 16), 16'h1 << (k % 16));
      see();
      chk(irqRequest, 1'b1);
      chk(pendingVectorNumber, 7'(k) + ICSR_FIRST_VECTOR);
      chk(pendingLevel, 4'(p));
      wr(ICSR_ENABLE_BASE_OFS + 6'(k / 16), 16'h0000);
      see();
      chk(irqRequest, 1'b0);
      wr(ICSR_ENABLE_BASE_OFS + 6'(k / 16), 16'h1 << (k % 16));
      wr(ICSR_CPU_STATUS_OFS, 16'(p) << 5);
      rd(ICSR_CPU_STATUS_OFS, 16'(p) << 5);
      see();
      chk(irqRequest, 1'b0);
      wr(ICSR_CPU_STATUS_OFS, 16'h0000);
      ackDelay <= 2'(xs());
      ackEnable <= 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(cpuPriorityLevel, 4'(p));
      ackEnable <= 1'b0;
      wr(ICSR_FLAG_BASE_OFS + 6'(k / 16), 16'h0000);
      rd(ICSR_FLAG_BASE_OFS + 6'(k / 16), 16'h0000);
      wr(ICSR_ENABLE_BASE_OFS + 6'(k / 16), 16'h0000);
      wr(ICSR_CPU_STATUS_OFS, 16'h0000);
    end
    $display("test sources done");
    wr(6'h09, 16'h0100);
    wr(6'h16, 16'h0007);
    ev(68'h1 << 40);
    see();
    chk(irqRequest, 1'b1);
    @(posedge clk);
    coreLevelLoad <= 1'b1;
    coreLevelValue <= 4'h8;
    @(posedge clk);
    coreLevelLoad <= 1'b0;
    see();
    chk(cpuPriorityLevel, 4'h8);
    chk(irqRequest, 1'b0);
    rd(ICSR_CORE_CONTROL_OFS, 16'h0008);
    wr(ICSR_CORE_CONTROL_OFS, 16'h0000);
    rd(ICSR_CORE_CONTROL_OFS, 16'h0008);
    @(posedge clk);
    coreLevelLoad <= 1'b1;
    coreLevelValue <= 4'h0;
    @(posedge clk);
    coreLevelLoad <= 1'b0;
    wr(ICSR_CPU_STATUS_OFS, 16'h00e0);
    see();
    chk(cpuPriorityLevel, 4'h7);
    chk(irqRequest, 1'b0);
    wr(ICSR_CPU_STATUS_OFS, 16'h0000);
    wr(ICSR_CTRL_ONE_OFS, 16'h8000);
    wr(ICSR_CPU_STATUS_OFS, 16'h00a0);
    rd(ICSR_CPU_STATUS_OFS, 16'h0000);
    wr(6'h16, 16'h0003);
    ackDelay <= 2'h0;
    ackEnable <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(cpuPriorityLevel, 4'h7);
    @(posedge clk);
    coreLevelLoad <= 1'b1;
    coreLevelValue <= 4'h0;
    @(posedge clk);
    coreLevelLoad <= 1'b0;
    see();
    chk(irqRequest, 1'b0);
    ackEnable <= 1'b0;
    see();
    chk(irqRequest, 1'b1);
    wr(ICSR_CTRL_ONE_OFS, 16'h0000);
    wr(6'h04, 16'h0000);
    wr(6'h09, 16'h0000);
    $display("test levels done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      extPin[i] <= 1'b1;
      rd(ICSR_FLAG_BASE_OFS + 6'(extSrc[i] / 16), 16'h1 << (extSrc[i] % 16));
      wr(ICSR_FLAG_BASE_OFS + 6'(extSrc[i] / 16), 16'h0000);
      wr(ICSR_CTRL_TWO_OFS, 16'h1 << i);
      extPin[i] <= 1'b0;
      rd(ICSR_FLAG_BASE_OFS + 6'(extSrc[i] / 16), 16'h1 << (extSrc[i] % 16));
      wr(ICSR_FLAG_BASE_OFS + 6'(extSrc[i] / 16), 16'h0000);
      wr(ICSR_CTRL_TWO_OFS, 16'h0000);
    end
    $display("test pins done");
    wr(ICSR_ENABLE_BASE_OFS, 16'h0220);
    wr(6'h0d, 16'h0030);
    wr(6'h0e, 16'h0030);
    ev((68'h1 << 5) | (68'h1 << 9));
    see();
    chk(pendingVectorNumber, 7'd13);
    wr(6'h0e, 16'h0050);
    see();
    chk(pendingVectorNumber, 7'd17);
    chk(pendingLevel, 4'h5);
    $display("test arbitration done");
    report_and_stop();
  end
endmodule : testbench
